/* aht_trigger.v */
// analog hysteresis trigger with a wishbone register file
`timescale 1ns/1ps
`include "aht_consts.vh"

module aht_trigger #(
	parameter VW = 32
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// scan, analog value and external thresholds
	input wire scan_i,
	input wire [15:0] analog_value_in_i,
	input wire signed [31:0] ext_on_i,
	input wire signed [31:0] ext_off_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// switch output and actual value
	output reg q_o,
	output reg signed [VW-1:0] actual_o
);

// ==========================================================
// clamp a signed word into +-lim
function signed [31:0] clampf;
	input signed [31:0] v;
	input [31:0] lim;
	begin
		if (v > $signed(lim))
			clampf = $signed(lim);
		else if (v < -$signed(lim))
			clampf = -$signed(lim);
		else
			clampf = v;
	end
endfunction

// byte-lane merge for writes
function [31:0] mergef;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] s;
	integer i;
	begin
		mergef = old;
		for (i = 0; i < 4; i = i + 1)
			if (s[i])
				mergef[i*8 +: 8] = nw[i*8 +: 8];
	end
endfunction

// ==========================================================
// registers
reg [5:0] ctrl_q;
reg signed [31:0] gain_q;
reg signed [31:0] offs_q;
reg signed [31:0] on_q;
reg signed [31:0] off_q;
wire [31:0] ctrl_w;
wire [31:0] gain_w;
wire [31:0] offs_w;
wire [31:0] on_w;
wire [31:0] off_w;
wire wr = cyc_i & stb_i & we_i & ~ack_o;

assign ctrl_w = mergef({26'h0, ctrl_q}, dat_i, sel_i);
assign gain_w = mergef(gain_q, dat_i, sel_i);
assign offs_w = mergef(offs_q, dat_i, sel_i);
assign on_w = mergef(on_q, dat_i, sel_i);
assign off_w = mergef(off_q, dat_i, sel_i);

always @(posedge clk_i) begin
	if (rst_i) begin
		ctrl_q <= 6'h00;
		gain_q <= `AHT_GAIN_RST;
		offs_q <= 32'h0;
		on_q <= 32'h0;
		off_q <= 32'h0;
	end else if (ce_i && wr) begin
		case (adr_i)
		`AHT_REG_CTRL: ctrl_q <= ctrl_w[5:0];
		`AHT_REG_GAIN: gain_q <= clampf(gain_w, `AHT_GAIN_MAX); // RQ3
		`AHT_REG_OFFS: offs_q <= clampf(offs_w, `AHT_OFFS_MAX); // RQ4
		`AHT_REG_ON: on_q <= clampf(on_w, `AHT_THR_MAX); // RQ5
		`AHT_REG_OFF: off_q <= clampf(off_w, `AHT_THR_MAX); // RQ5
		default: ;
		endcase
	end
end

// ==========================================================
// read path and ack; one wait state, unmapped reads return zero
always @(posedge clk_i) begin
	if (rst_i) begin
		ack_o <= 1'b0;
		dat_o <= 32'h0;
	end else if (ce_i) begin
		ack_o <= cyc_i & stb_i & ~ack_o;
		case (adr_i)
		`AHT_REG_CTRL: dat_o <= {26'h0, ctrl_q};
		`AHT_REG_GAIN: dat_o <= gain_q;
		`AHT_REG_OFFS: dat_o <= offs_q;
		`AHT_REG_ON: dat_o <= on_q;
		`AHT_REG_OFF: dat_o <= off_q;
		`AHT_REG_STAT: dat_o <= {31'h0, q_o};
		`AHT_REG_VAL: dat_o <= actual_o;
		default: dat_o <= 32'h0;
		endcase
	end
end

// ==========================================================
// scaling; 64-bit intermediates cannot overflow
wire signed [63:0] in_w;
wire signed [63:0] g_w;
wire signed [63:0] b_w;
wire signed [63:0] prod_w;
wire signed [63:0] act_w;
wire signed [31:0] on_sel;
wire signed [31:0] off_sel;
wire signed [63:0] act_on;
wire signed [63:0] act_off;

// input clipped to the internal 0..1000 span
assign in_w = (analog_value_in_i > `AHT_IN_MAX) ?
	64'sd1000 : {48'h0, analog_value_in_i}; // RQ1
assign g_w = {{32{gain_q[31]}}, gain_q};
assign b_w = {{32{offs_q[31]}}, offs_q};
// gain is in hundredths, so divide after the multiply
assign prod_w = ctrl_q[`AHT_CTRL_LEGACY] ?
	((in_w + b_w) * g_w) / 64'sd100 : // RQ11
	(in_w * g_w) / 64'sd100 + b_w; // RQ6
assign act_w = prod_w; // RQ13

// decimal places in ctrl only shape display, never these compares
assign on_sel = ctrl_q[`AHT_CTRL_ON_EXT] ? ext_on_i : on_q; // RQ10
assign off_sel = ctrl_q[`AHT_CTRL_OFF_EXT] ? ext_off_i : off_q; // RQ10 RQ9
assign act_on = {{32{on_sel[31]}}, on_sel};
assign act_off = {{32{off_sel[31]}}, off_sel};

// ==========================================================
// output, updated once per scan
always @(posedge clk_i) begin
	if (rst_i) begin
		q_o <= 1'b0; // RQ13
		actual_o <= {VW{1'b0}};
	end else if (ce_i && scan_i) begin
		actual_o <= act_w[VW-1:0];
		if (ctrl_q[`AHT_CTRL_LEGACY] || act_on >= act_off) begin
			if (act_w > act_on)
				q_o <= 1'b1; // RQ7 RQ11
			else if (act_w <= act_off)
				q_o <= 1'b0; // RQ7 RQ11
		end else begin
			q_o <= (act_w >= act_on) && (act_w < act_off); // RQ8
		end
	end
end

endmodule // aht_trigger

/* aht_consts.vh */
// constants and register map of the analog hysteresis trigger
// Contract
// (RQ1) input is an integer word, full-scale voltage maps to 0..1000
// (RQ2) input comes from an analog channel, marker, output or another block
// (RQ3) gain is signed hundredths, magnitude limited to 10.00
// (RQ4) zero offset is a signed integer, magnitude limited to 10000
// (RQ5) on and off thresholds are signed integers, magnitude limited to 20000
// (RQ6) actual value is input times gain plus offset, used by all compares
// (RQ7) on >= off: set when value above on, clear at or below off, else hold
// (RQ8) on < off: output high exactly while on <= value < off
// (RQ9) decimal places 0..3 affect display only, never the comparison
// (RQ10) thresholds may come from another block's result instead of constants
// (RQ11) legacy mode adds offset before gain, same set and clear thresholds
// (RQ12) configurer uses one decimal setting for range minimum and maximum
// (RQ13) evaluate once per scan, output low after reset, no overflow
`ifndef AHT_CONSTS_VH
`define AHT_CONSTS_VH

// ==========================================================
// register offsets
`define AHT_REG_CTRL 8'h00
`define AHT_REG_GAIN 8'h04
`define AHT_REG_OFFS 8'h08
`define AHT_REG_ON 8'h0c
`define AHT_REG_OFF 8'h10
`define AHT_REG_STAT 8'h14
`define AHT_REG_VAL 8'h18

// ==========================================================
// control fields
`define AHT_CTRL_LEGACY 0
`define AHT_CTRL_ON_EXT 1
`define AHT_CTRL_OFF_EXT 2
`define AHT_CTRL_DEC_LO 4
`define AHT_CTRL_DEC_HI 5

// ==========================================================
// limits and reset values
`define AHT_IN_MAX 32'h000003e8
`define AHT_GAIN_MAX 32'h000003e8
`define AHT_OFFS_MAX 32'h00002710
`define AHT_THR_MAX 32'h00004e20
`define AHT_GAIN_RST 32'h00000064
`define AHT_GAIN_DIV 32'h00000064

`endif

/* aht_src.sv */
// analog value source with a periodic scan strobe
`timescale 1ns/1ps
module aht_src (
	// clock, wanted value, value and strobe out
	input wire clk_i,
	input wire [15:0] v_i,
	output reg [15:0] val_o = 16'h0,
	output reg scan_o = 1'b0
);
	reg [1:0] cnt_q = 2'h0;
	// fixed four-cycle scan keeps the answer latency bounded
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 2'h1;
		scan_o <= cnt_q == 2'h3;
		val_o <= v_i;
	end
endmodule // aht_src

/* aht_trigger_monitor.sv */
// port checker of the analog hysteresis trigger
`timescale 1ns/1ps
module aht_trigger_monitor #(parameter VW = 32) (
	// watched ports
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire scan_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire q_o,
	input wire signed [VW-1:0] actual_o
);
	wire req = cyc_i && stb_i && !ack_o && ce_i;
	wire scn = scan_i && ce_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_once_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack");
	ack_due_a: assert property (req |=> ack_o) else $error("no ack");
	ack_why_a: assert property ($rose(ack_o) |-> $past(req)) else $error("stray");
	ack_idle_a: assert property (!stb_i && ce_i |=> !ack_o) else $error("idle");
	q_hold_a:
		assert property ($changed(q_o) |-> $past(scn)) else $error("q");
	v_hold_a:
		assert property ($changed(actual_o) |-> $past(scn)) else $error("v");
	v_keep_a:
		assert property (!scn |=> $stable(actual_o)) else $error("v keep");
	rst_clr_a:
		assert property (disable iff (1'b0) rst_i |=> !q_o && actual_o == '0)
		else $error("rst");
	cover property ($rose(q_o));
	cover property ($fell(q_o));
	cover property (req ##1 ack_o);
endmodule // aht_trigger_monitor
bind aht_trigger aht_trigger_monitor #(.VW(VW)) u_mon (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .scan_i(scan_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .ack_o(ack_o), .q_o(q_o), .actual_o(actual_o));

/* aht_trigger_tb.sv */
// bench of the analog hysteresis trigger
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
	mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
module aht_trigger_tb;
	reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, we_i = 1'b0;
	reg [7:0] adr_i = 8'h0;
	reg [15:0] v = 16'h0;
	reg ce = 1'b1;
	reg [31:0] dat_i = 32'h0, rd = 32'h0, eon = 32'h0, eoff = 32'h0;
	wire ack_o, q_o, scan;
	wire [15:0] val;
	wire [31:0] dat_o, act;
	int mismatches = 0, cmp_count = 0;
	always #50 clk_i = ~clk_i;
	aht_src i_src (.clk_i(clk_i), .v_i(v), .val_o(val), .scan_o(scan));
	aht_trigger i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.scan_i(scan), .analog_value_in_i(val), .ext_on_i(eon),
		.ext_off_i(eoff), .cyc_i(cyc_i), .stb_i(cyc_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .q_o(q_o), .actual_o(act));
	task wb(input [7:0] a, input [31:0] d, input w);
		@(posedge clk_i);
		{cyc_i, we_i, adr_i, dat_i} <= {1'b1, w, a, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
	endtask
	// fixed wait covers two scan periods of the source
	task sv(input [15:0] x, input e);
		@(posedge clk_i);
		v <= x;
		repeat (8) @(posedge clk_i);
		`CHK(q_o, e)
	endtask
	task report_and_stop;
		if (mismatches == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task t_band;
		wb(8'hc, 32'h1f4, 1'b1);
		wb(8'h10, 32'h12c, 1'b1);
		sv(16'h258, 1'b1);
		sv(16'h12d, 1'b1);
		sv(16'h12c, 1'b0);
		wb(8'hc, 32'h12c, 1'b1);
		wb(8'h10, 32'h1f4, 1'b1);
		sv(16'h12b, 1'b0);
		sv(16'h12c, 1'b1);
		sv(16'h1f4, 1'b0);
	endtask
	task t_scale;
		wb(8'h4, 32'h7d0, 1'b1);
		wb(8'h4, 32'h0, 1'b0);
		`CHK(rd, 32'h3e8)
		wb(8'h8, 32'hffffb1e0, 1'b1);
		wb(8'h8, 32'h0, 1'b0);
		`CHK(rd, 32'hffffd8f0)
		wb(8'h4, 32'hffffff06, 1'b1);
		wb(8'h0, 32'h30, 1'b1);
		sv(16'h7d0, 1'b0);
		`CHK(act, 32'hffffcf2c)
	endtask
	task t_mode;
		wb(8'h0, 32'h1, 1'b1);
		wb(8'h4, 32'hc8, 1'b1);
		wb(8'h8, 32'h64, 1'b1);
		wb(8'h10, 32'h0, 1'b1);
		wb(8'hc, 32'h12b, 1'b1);
		sv(16'h32, 1'b1);
		`CHK(act, 32'h12c)
		{eon, eoff} <= {32'ha, 32'h5};
		wb(8'h0, 32'h6, 1'b1);
		wb(8'h4, 32'h64, 1'b1);
		wb(8'h8, 32'h0, 1'b1);
		sv(16'h5, 1'b0);
		sv(16'hb, 1'b1);
		wb(8'h14, 32'h0, 1'b0);
		`CHK(rd, 32'h1)
	endtask
	// a low enable must freeze the switch even across scan strobes
	task t_freeze;
		@(posedge clk_i);
		ce <= 1'b0;
		v <= 16'h5;
		repeat (8) @(posedge clk_i);
		`CHK(q_o, 1'b1)
		ce <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK(q_o, 1'b0)
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(8'h4, 32'h0, 1'b0);
		`CHK(rd, 32'h64)
		`CHK(q_o, 1'b0)
		wb(8'h1c, 32'h0, 1'b0);
		`CHK(rd, 32'h0)
		t_band;
		t_scale;
		t_mode;
		t_freeze;
		report_and_stop;
	end
	initial begin
		#200000;
		mismatches++;
		report_and_stop;
	end
endmodule // aht_trigger_tb
